// File: rtl/sci_pkg.sv
`default_nettype none
package sci_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_BAUD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;
  localparam logic [7:0] OFF_PORT = 8'h10;
  // baud control field
  localparam int BAUD_W = 13;
  localparam logic [12:0] BAUD_RESET = 13'h0004;
  localparam logic [4:0] SAMPLES_PER_BIT = 5'h10;
  localparam logic [4:0] TICKS_PER_SAMPLE = 5'h02;
  // config bit positions
  localparam int CFG_PT = 0;
  localparam int CFG_PE = 1;
  localparam int CFG_M = 2;
  localparam int CFG_OPEN_DRAIN_SELECT = 3;
  localparam int CFG_SBK = 4;
  localparam int CFG_TE = 5;
  localparam int CFG_RE = 6;
  localparam int CFG_TX_COMPLETE_IRQ_ENABLE = 7;
  localparam int CFG_TIE = 8;
  localparam int CFG_RIE = 9;
  localparam logic [9:0] CFG_RESET = 10'h000;
  // status bit positions
  localparam int ST_PF = 0;
  localparam int ST_FE = 1;
  localparam int ST_OR = 2;
  localparam int ST_RX_BUFFER_FULL = 6;
  localparam int ST_TC = 7;
  localparam int ST_TX_BUFFER_EMPTY = 8;
  localparam logic [8:0] ST_RESET = 9'h180;
  localparam logic [8:0] ST_RX_MASK = 9'h047;
  // port control bit positions
  localparam int PORT_ASSIGN = 0;
  localparam int PORT_DIR = 1;
  localparam int PORT_LEVEL = 2;
  // three high samples before a start edge
  localparam logic [1:0] START_HIGH_SAMPLES = 2'h3;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_DATA = 4'b0010,
    TX_PREAMBLE = 4'b0100,
    TX_BREAK = 4'b1000
  } tx_state_t;
endpackage : sci_pkg
`default_nettype wire

// File: rtl/baud_gen.sv
`default_nettype none
module baud_gen
  import sci_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // divisor
  input wire logic [12:0] divisor,
  // ticks
  output logic rx_sample_tick,
  output logic bit_tick
);
  logic [12:0] mod_q;
  logic [4:0] half_q;
  logic [4:0] samp_q;
  logic mod_hit;
  // a divisor cut below the running count must not leave the counter to wrap the full range
  assign mod_hit = (divisor != 13'h0000) && (mod_q >= divisor - 13'h0001);
  // modulus counter; a zero divisor parks everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_q <= 13'h0000;
      half_q <= 5'h00;
      samp_q <= 5'h00;
      rx_sample_tick <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      rx_sample_tick <= 1'b0;
      bit_tick <= 1'b0;
      if (divisor == 13'h0000) begin // [R10]
        mod_q <= 13'h0000;
        half_q <= 5'h00;
        samp_q <= 5'h00;
      end else if (mod_hit) begin
        mod_q <= 13'h0000;
        // clk/(2*div) gives 16x of clk/(32*div)
        if (half_q == TICKS_PER_SAMPLE - 5'h01) begin // [R11]
          half_q <= 5'h00;
          rx_sample_tick <= 1'b1;
          if (samp_q == SAMPLES_PER_BIT - 5'h01) begin
            samp_q <= 5'h00;
            bit_tick <= 1'b1;
          end else begin
            samp_q <= samp_q + 5'h01;
          end
        end else begin
          half_q <= half_q + 5'h01;
        end
      end else begin
        mod_q <= mod_q + 13'h0001;
      end
    end
  end
endmodule : baud_gen
`default_nettype wire

// File: rtl/sci_rx.sv
`default_nettype none
module sci_rx
  import sci_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic enable,
  input wire logic long_frame,
  input wire logic parity_enable,
  input wire logic parity_odd_select,
  input wire logic rx_sample_tick,
  input wire logic rxd,
  // result, one-cycle strobe
  output logic done,
  output logic [8:0] data,
  output logic parity_bad,
  output logic frame_bad
);
  logic busy_q;
  logic [1:0] ones_q;
  logic [3:0] phase_q;
  logic [3:0] nbits_q;
  logic [10:0] sh_q;
  logic prev_q;
  logic [3:0] frame_bits;
  assign frame_bits = long_frame ? 4'd11 : 4'd10;
  // sample at mid-bit; each falling edge restarts the phase so sampling realigns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      ones_q <= 2'h0;
      phase_q <= 4'h0;
      nbits_q <= 4'h0;
      sh_q <= 11'h000;
      prev_q <= 1'b1;
      done <= 1'b0;
      data <= 9'h000;
      parity_bad <= 1'b0;
      frame_bad <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!enable) begin
        busy_q <= 1'b0;
        ones_q <= 2'h0;
      end else if (rx_sample_tick) begin
        prev_q <= rxd;
        if (!busy_q) begin
          if (rxd && ones_q != START_HIGH_SAMPLES) begin
            ones_q <= ones_q + 2'h1;
          end else if (!rxd && ones_q == START_HIGH_SAMPLES) begin // [R7]
            busy_q <= 1'b1;
            phase_q <= 4'h1;
            nbits_q <= 4'h0;
          end else if (!rxd) begin
            ones_q <= 2'h0;
          end
        end else begin
          if (prev_q && !rxd) begin
            phase_q <= 4'h1; // [R11]
          end else begin
            phase_q <= phase_q + 4'h1;
          end
          if (phase_q == 4'h7) begin
            sh_q <= {rxd, sh_q[10:1]};
            nbits_q <= nbits_q + 4'h1;
            if (nbits_q == frame_bits - 4'h1) begin // [R23]
              busy_q <= 1'b0;
              ones_q <= 2'h0;
              done <= 1'b1;
              frame_bad <= ~rxd;
              if (long_frame) begin
                data <= sh_q[10:2];
                parity_bad <= parity_enable & ((^sh_q[10:3]) ^ sh_q[2] ^ parity_odd_select); // [R12]
              end else begin
                data <= {1'b0, sh_q[10:3]};
                parity_bad <= parity_enable & ((^sh_q[9:3]) ^ sh_q[10] ^ parity_odd_select);
              end
            end
          end
        end
      end
    end
  end
endmodule : sci_rx
`default_nettype wire

// File: rtl/sci_top.sv
// How it works
// [R1] status read then data access clears flags
// [R2] long-word read clears rx flags only
// [R3] flags set after status read stay set
// [R4] any status byte read arms all flags
// [R5] one data address: rx read, tx write
// [R6] rx dedicated; tx pin is gpio when disabled
// [R7] start, idle and break frame shapes
// [R8] 10 or 11 bit frames, lsb first
// [R9] data width from frame length and parity
// [R10] baud is clock over 32 times divisor
// [R11] sample tick at sixteen times baud
// [R12] msb parity, even or odd, checked
// [R13] double buffered; shifter keeps pin while busy
// [R14] open-drain select for both pin uses
// [R15] buffer empty flag and write discard
// [R16] complete flag cleared by read then write
// [R17] enabling sends idle preamble
// [R18] break frames while send break set
// [R19] all sent: empty, complete, line high
// [R20] disable finishes frames, drops buffer
// [R21] re-enable before empty sends preamble
// [R22] separate tx empty and complete requests
// [R23] full frame moves to rx buffer
// [R24] request is flag and enable level
// [R25] stop and idle bits are whole bit-times
//
// Implementation choices: the APB slave port and the register offsets.
`default_nettype none
module sci_top
  import sci_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic rxd,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe,
  // requests
  output logic tx_empty_irq,
  output logic tx_complete_irq,
  output logic rx_full_irq
);
  logic [12:0] baud_divisor_q;
  logic [9:0] cfg_q;
  logic [2:0] port_q;
  logic [8:0] status_q;
  logic [8:0] armed_q;
  logic [8:0] receive_buffer_q;
  logic [8:0] transmit_buffer_q;
  logic [10:0] shift_q;
  logic [3:0] bits_left_q;
  logic [3:0] sub_q;
  logic te_prev_q;
  logic preamble_pend_q;
  logic shifter_pin_q;
  logic break_pend_q;
  logic tx_step;
  logic tx_load;
  tx_state_t state_q;
  logic rx_sample_tick;
  logic bit_tick;
  logic rx_done;
  logic [8:0] rx_data;
  logic rx_pbad;
  logic rx_fbad;
  logic access;
  logic wr;
  logic rd;
  logic status_rd;
  logic data_rd;
  logic data_wr;
  logic long_rd;
  logic load_shifter;
  logic frame_end;
  logic te;
  logic [3:0] frame_len;
  logic tx_par;
  logic [10:0] data_frame;
  logic pin_level;
  // apb decode; single-wait-free slave
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  // a long-word read of status covers the data word in the same transfer
  assign long_rd = rd && paddr == OFF_STATUS && pstrb == 4'h0;
  assign status_rd = rd && paddr == OFF_STATUS; // [R4]
  assign data_rd = rd && paddr == OFF_DATA;
  assign data_wr = wr && paddr == OFF_DATA && pstrb[1:0] != 2'h0;
  assign te = cfg_q[CFG_TE];
  assign frame_len = cfg_q[CFG_M] ? 4'd11 : 4'd10; // [R8]
  // parity over the data bits below the msb slot
  assign tx_par = cfg_q[CFG_M] ? ((^transmit_buffer_q[7:0]) ^ cfg_q[CFG_PT])
                               : ((^transmit_buffer_q[6:0]) ^ cfg_q[CFG_PT]); // [R12]
  // frame: start low, data lsb first, stop high
  always_comb begin
    data_frame = 11'h7ff;
    data_frame[0] = 1'b0; // [R7]
    if (cfg_q[CFG_M]) begin
      data_frame[9:1] = cfg_q[CFG_PE] ? {tx_par, transmit_buffer_q[7:0]} : transmit_buffer_q; // [R9]
    end else begin
      data_frame[8:1] = cfg_q[CFG_PE] ? {tx_par, transmit_buffer_q[6:0]} : transmit_buffer_q[7:0]; // [R9]
    end
  end
  assign frame_end = bit_tick && bits_left_q == 4'h1; // [R25]
  assign load_shifter = !status_q[ST_TX_BUFFER_EMPTY] && te && !preamble_pend_q && !cfg_q[CFG_SBK] && !break_pend_q;
  // leave idle only on a bit boundary so the first bit is a whole bit-time
  assign tx_step = frame_end || (state_q == TX_IDLE && bit_tick); // [R25]
  assign tx_load = tx_step && load_shifter && state_q != TX_BREAK; // [R15]

  baud_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(baud_divisor_q),
    .rx_sample_tick(rx_sample_tick),
    .bit_tick(bit_tick)
  );

  sci_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .enable(cfg_q[CFG_RE]),
    .long_frame(cfg_q[CFG_M]),
    .parity_enable(cfg_q[CFG_PE]),
    .parity_odd_select(cfg_q[CFG_PT]),
    .rx_sample_tick(rx_sample_tick),
    .rxd(rxd), // [R6]
    .done(rx_done),
    .data(rx_data),
    .parity_bad(rx_pbad),
    .frame_bad(rx_fbad)
  );

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_divisor_q <= BAUD_RESET;
      cfg_q <= CFG_RESET;
      port_q <= 3'h0;
    end else if (wr) begin
      unique case (paddr)
        OFF_BAUD: baud_divisor_q <= pwdata[12:0];
        OFF_CFG: cfg_q <= pwdata[9:0];
        OFF_PORT: port_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // arming: a status read snapshots set flags; later sets are not armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 9'h000;
    end else if (status_rd) begin
      armed_q <= status_q; // [R3]
    end else if (data_rd) begin
      armed_q <= armed_q & ~ST_RX_MASK;
    end else if (data_wr) begin
      armed_q <= armed_q & ST_RX_MASK;
    end
  end

  // status flags; hardware set wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= ST_RESET;
    end else begin
      if (data_rd) begin
        status_q <= status_q & ~(armed_q & ST_RX_MASK); // [R1]
      end else if (long_rd) begin
        status_q <= status_q & ~ST_RX_MASK; // [R2]
      end else if (data_wr) begin
        status_q[ST_TX_BUFFER_EMPTY] <= status_q[ST_TX_BUFFER_EMPTY] & ~armed_q[ST_TX_BUFFER_EMPTY]; // [R15]
        status_q[ST_TC] <= status_q[ST_TC] & ~armed_q[ST_TC]; // [R16]
      end
      if (rx_done) begin
        if (status_q[ST_RX_BUFFER_FULL] && !(data_rd && armed_q[ST_RX_BUFFER_FULL])) begin
          status_q[ST_OR] <= 1'b1;
        end else begin
          status_q[ST_RX_BUFFER_FULL] <= 1'b1; // [R23]
          status_q[ST_PF] <= rx_pbad; // [R12]
          status_q[ST_FE] <= rx_fbad;
        end
      end
      if (tx_load) begin
        status_q[ST_TX_BUFFER_EMPTY] <= 1'b1; // [R15]
      end
      if (te && !te_prev_q) begin
        status_q[ST_TC] <= 1'b0;
      end else if (state_q != TX_IDLE && frame_end && !(te && (load_shifter || cfg_q[CFG_SBK] || break_pend_q))) begin
        status_q[ST_TC] <= 1'b1; // [R19]
      end
      if (!te && state_q == TX_IDLE) begin
        status_q[ST_TX_BUFFER_EMPTY] <= 1'b1; // [R20]
      end
    end
  end

  // buffers; a write while the buffer is full is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer_q <= 9'h000;
      transmit_buffer_q <= 9'h000;
    end else begin
      if (rx_done && !(status_q[ST_RX_BUFFER_FULL] && !(data_rd && armed_q[ST_RX_BUFFER_FULL]))) begin
        receive_buffer_q <= rx_data; // [R23]
      end
      if (data_wr && status_q[ST_TX_BUFFER_EMPTY] && armed_q[ST_TX_BUFFER_EMPTY]) begin
        transmit_buffer_q <= pwdata[8:0]; // [R5]
      end
    end
  end

  // transmit sequencer: idle, preamble, data and break frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TX_IDLE;
      shift_q <= 11'h7ff;
      bits_left_q <= 4'h0;
      sub_q <= 4'h0;
      te_prev_q <= 1'b0;
      preamble_pend_q <= 1'b0;
      shifter_pin_q <= 1'b0;
      break_pend_q <= 1'b0;
    end else begin
      te_prev_q <= te;
      sub_q <= 4'h0;
      if (te && !te_prev_q) begin
        preamble_pend_q <= 1'b1; // [R17] [R21]
      end
      // a short pulse of send break still earns one whole break frame
      if (!te) begin
        break_pend_q <= 1'b0;
      end else if (cfg_q[CFG_SBK] && state_q != TX_BREAK) begin
        break_pend_q <= 1'b1; // [R18]
      end
      if (tx_step) begin
        if (state_q != TX_IDLE && !te) begin
          state_q <= TX_IDLE; // [R20]
          shift_q <= 11'h7ff;
        end else if (te && preamble_pend_q) begin
          state_q <= TX_PREAMBLE; // [R17]
          shift_q <= 11'h7ff;
          bits_left_q <= frame_len;
          preamble_pend_q <= 1'b0;
        end else if (te && (cfg_q[CFG_SBK] || break_pend_q)) begin
          state_q <= TX_BREAK; // [R18]
          break_pend_q <= 1'b0;
          shift_q <= 11'h000;
          bits_left_q <= frame_len;
        end else if (state_q == TX_BREAK) begin
          state_q <= TX_PREAMBLE; // [R18]
          shift_q <= 11'h7ff;
          bits_left_q <= 4'h1;
        end else if (load_shifter) begin
          state_q <= TX_DATA; // [R13]
          shift_q <= data_frame;
          bits_left_q <= frame_len;
        end else begin
          state_q <= TX_IDLE; // [R19]
          shift_q <= 11'h7ff;
        end
      end else if (bit_tick) begin
        shift_q <= {1'b1, shift_q[10:1]};
        bits_left_q <= bits_left_q - 4'h1;
      end
      shifter_pin_q <= te || state_q != TX_IDLE; // [R13]
    end
  end

  // pin level: shifter owns it while operating, else port bits
  assign pin_level = shifter_pin_q ? shift_q[0] : port_q[PORT_LEVEL]; // [R6]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1;
      txd_oe <= 1'b0;
    end else begin
      txd_out <= pin_level;
      if (shifter_pin_q || (port_q[PORT_ASSIGN] && port_q[PORT_DIR])) begin
        txd_oe <= cfg_q[CFG_OPEN_DRAIN_SELECT] ? ~pin_level : 1'b1; // [R14]
      end else begin
        txd_oe <= 1'b0;
      end
    end
  end

  // interrupt request levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_irq <= 1'b0;
      tx_complete_irq <= 1'b0;
      rx_full_irq <= 1'b0;
    end else begin
      tx_empty_irq <= status_q[ST_TX_BUFFER_EMPTY] & cfg_q[CFG_TIE]; // [R22] [R24]
      tx_complete_irq <= status_q[ST_TC] & cfg_q[CFG_TX_COMPLETE_IRQ_ENABLE]; // [R22] [R24]
      rx_full_irq <= status_q[ST_RX_BUFFER_FULL] & cfg_q[CFG_RIE]; // [R24]
    end
  end

  // apb read data; unmapped reads return zero with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          OFF_BAUD: prdata <= {19'h00000, baud_divisor_q};
          OFF_CFG: prdata <= {22'h000000, cfg_q};
          OFF_STATUS: prdata <= {7'h00, receive_buffer_q, 7'h00, status_q};
          OFF_DATA: prdata <= {23'h000000, receive_buffer_q};
          OFF_PORT: prdata <= {28'h0000000, txd_in, port_q};
          default: pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        pslverr <= !(paddr == OFF_BAUD || paddr == OFF_CFG || paddr == OFF_STATUS ||
                     paddr == OFF_DATA || paddr == OFF_PORT);
      end
    end
  end
endmodule : sci_top
`default_nettype wire

// File: sim/sci_properties.sv
`default_nettype none
module sci_properties
  import sci_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic rxd,
  input wire logic txd_in,
  input wire logic txd_out,
  input wire logic txd_oe,
  // requests
  input wire logic tx_empty_irq,
  input wire logic tx_complete_irq,
  input wire logic rx_full_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cfg_q;
  logic [7:0] run_q;
  logic last_q;
  wire logic wr_done = psel && penable && pready && pwrite;
  wire logic acc_done = psel && penable && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pin_moved;
    txd_out != last_q && txd_oe && $past(txd_oe);
  endsequence
  // shadow of the config word, pin and request rules depend on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_q <= CFG_RESET;
    else if (wr_done && paddr == OFF_CFG) cfg_q <= pwdata[9:0];
  end
  // cycles since the pin last moved; saturates so idle time never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 1'b1;
      run_q <= 8'hff;
    end else begin
      last_q <= txd_out;
      run_q <= (txd_out != last_q) ? 8'h00 : ((run_q == 8'hff) ? run_q : run_q + 8'h01);
    end
  end
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no answer in the access cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_err_unmapped: assert property (s_setup and paddr > OFF_PORT |=> pready && pslverr)
    else $error("unmapped access not flagged");
  a_bit_time_min: assert property (s_pin_moved |-> run_q >= 8'h1f)
    else $error("pin moved within one bit-time");
  a_open_drain_low: assert property (cfg_q[CFG_OPEN_DRAIN_SELECT] && $past(cfg_q[CFG_OPEN_DRAIN_SELECT], 2) && txd_oe |-> !txd_out)
    else $error("open-drain pin driven high");
  a_empty_irq_gated: assert property (tx_empty_irq |-> cfg_q[CFG_TIE] || $past(cfg_q[CFG_TIE]))
    else $error("empty request without enable");
  a_done_irq_gated: assert property (tx_complete_irq |-> cfg_q[CFG_TX_COMPLETE_IRQ_ENABLE] || $past(cfg_q[CFG_TX_COMPLETE_IRQ_ENABLE]))
    else $error("complete request without enable");
  a_rx_irq_gated: assert property (rx_full_irq |-> cfg_q[CFG_RIE] || $past(cfg_q[CFG_RIE]))
    else $error("receive request without enable");
  a_rx_clear_access: assert property ($fell(rx_full_irq) |-> $past(acc_done) || $past(acc_done, 2))
    else $error("receive flag dropped without access");
  a_tc_clear_write: assert property ($fell(tx_complete_irq) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("complete flag dropped without write");
endmodule : sci_properties
bind sci_top sci_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .txd_in(txd_in), .txd_out(txd_out), .txd_oe(txd_oe),
  .tx_empty_irq(tx_empty_irq), .tx_complete_irq(tx_complete_irq), .rx_full_irq(rx_full_irq));
`default_nettype wire

// File: sim/serial_peer.sv
`default_nettype none
module serial_peer #(
  parameter int BIT_CYC = 32
) (
  // clock
  input wire logic pclk,
  // line and format
  input wire logic line,
  input wire logic long_frame,
  // towards the block
  output logic rxd,
  // captured frame, bits after the start bit
  output logic got,
  output logic [9:0] bits
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    bits = 10'h000;
  end
  // start edge confirmed at mid-bit, then sampled once per bit
  always begin
    @(negedge line);
    repeat (BIT_CYC / 2) @(posedge pclk);
    if (line === 1'b0) begin
      bits = 10'h000;
      for (int i = 0; i < (long_frame ? 10 : 9); i++) begin
        repeat (BIT_CYC) @(posedge pclk);
        bits[i] = line;
      end
      got <= 1'b1;
      @(posedge pclk);
      got <= 1'b0;
      // a break has no stop bit, so wait for mark before hunting
      wait (line === 1'b1);
    end
  end
  // start at once, bits lsb first, then one bit of mark
  task automatic send(input logic [9:0] b, input int nb);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= b[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge pclk);
  endtask : send
endmodule : serial_peer
`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_top
  import sci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic peer_long = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd, txd_out, txd_oe, tx_empty_irq, tx_complete_irq, rx_full_irq, got;
  logic [9:0] bits;
  wire logic line = txd_oe ? txd_out : 1'b1;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [65:0] rd_q[$];
  logic [9:0] fr_q[$];
  logic [31:0] seed = 32'h0ac9c756;
  always #4 pclk = ~pclk;
  sci_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd_in(line), .txd_out(txd_out), .txd_oe(txd_oe), .tx_empty_irq(tx_empty_irq),
    .tx_complete_irq(tx_complete_irq), .rx_full_irq(rx_full_irq));
  serial_peer #(.BIT_CYC(32)) peer (.pclk(pclk), .line(line), .long_frame(peer_long), .rxd(rxd),
    .got(got), .bits(bits));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // bits after the start bit, stop included
  function automatic logic [9:0] frame(input logic [8:0] d, input logic m, input logic pe, input logic pt);
    if (!pe) return m ? {1'b1, d} : {2'b01, d[7:0]};
    if (!m) return {2'b01, ^d[6:0] ^ pt, d[6:0]};
    return {1'b1, ^d[7:0] ^ pt, d[7:0]};
  endfunction : frame
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // one apb transfer; expectation is {error, data} under a mask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ex,
      input logic [32:0] mk);
    rd_q.push_back({mk, ex});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? 4'hf : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h100000000);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
    apb(1'b0, a, 32'h0, {1'b0, ex}, {1'b1, mk});
  endtask : rd
  // 0 complete, 1 receive full, 2 buffer empty
  task automatic wait_irq(input int k, output int n);
    logic v;
    n = 0;
    repeat (3) @(posedge pclk);
    do begin
      @(posedge pclk);
      n++;
      v = (k == 0) ? tx_complete_irq : ((k == 1) ? rx_full_irq : tx_empty_irq);
    end while (v !== 1'b1 && n < 5000);
  endtask : wait_irq
  // completed transfers against the oldest note
  always @(posedge pclk) begin
    logic [65:0] e;
    if (psel && penable && pready) begin
      e = rd_q.pop_front();
      `CHK({pslverr, prdata} & e[65:33], e[32:0] & e[65:33])
    end
  end
  // frames seen on the line; an unexpected one meets an unknown
  always @(posedge pclk) begin
    if (got === 1'b1) `CHK(bits, (fr_q.size() != 0) ? fr_q.pop_front() : 10'bx)
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    int n;
    logic [3:0] md;
    logic bad;
    logic [8:0] dm;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_STATUS, {23'h0, ST_RESET}, 32'h1ff);
    rd(OFF_BAUD, {19'h0, BAUD_RESET}, 32'h1fff);
    apb(1'b0, 8'h40, 32'h0, 33'h100000000, 33'h100000000);
    // pin as a general-purpose output while the sender is off
    wr(OFF_PORT, 32'h7);
    rd(OFF_PORT, 32'h8, 32'h8);
    `CHK({txd_oe, txd_out}, 2'b11)
    wr(OFF_PORT, 32'h0);
    @(posedge pclk);
    `CHK(txd_oe, 1'b0)
    wr(OFF_BAUD, 32'h1);
    // enable sends ten marks before complete rises
    wr(OFF_CFG, 32'h3e0);
    wait_irq(0, n);
    `CHK(n inside {[318:353]}, 1'b1)
    // two loads back to back, then one with no fresh status read
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wait_irq(2, n);
      if (i < 2) begin
        rd(OFF_STATUS, 32'h100, 32'h100);
        fr_q.push_back(frame(seed[8:0], 1'b0, 1'b0, 1'b0));
      end
      wr(OFF_DATA, seed);
    end
    wait_irq(0, n);
    // format table, low nibble first: parity type, parity, long, open drain
    for (int i = 0; i < 5; i++) begin
      md = 20'hf4320 >> (i * 4);
      wr(OFF_CFG, 32'h3e0 | md);
      peer_long <= md[2];
      seed = lfsr(seed);
      rd(OFF_STATUS, 32'h0, 32'h0);
      wr(OFF_DATA, seed);
      fr_q.push_back(frame(seed[8:0], md[2], md[1], md[0]));
      wait_irq(0, n);
      // echo back, parity spoiled on odd formats
      bad = md[1] & md[0];
      peer.send(frame(seed[8:0], md[2], md[1], md[0]) ^ (bad ? (md[2] ? 10'h100 : 10'h080) : 10'h0),
        md[2] ? 10 : 9);
      wait_irq(1, n);
      dm = (md[2] & !md[1]) ? 9'h1ff : ((md[1] & !md[2]) ? 9'h07f : 9'h0ff);
      rd(OFF_STATUS, {7'h0, seed[8:0], 16'h0040} | bad, {7'h0, dm, 16'h0041});
      rd(OFF_STATUS, 32'h180, 32'h1c0);
    end
    // brief break request gives one frame of zeros
    peer_long <= 1'b0;
    wr(OFF_CFG, 32'h3f0);
    wr(OFF_CFG, 32'h3e0);
    fr_q.push_back(10'h000);
    repeat (800) @(posedge pclk);
    `CHK({txd_oe, txd_out, tx_complete_irq}, 3'b111)
    `CHK(fr_q.size(), 0)
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
